// >>> core/emd_pkg.sv
package emd_pkg;

    // Pin widths and piece counter width.
    localparam int ADDR_W = 28;
    localparam int LANE_W = 4;
    localparam int SUB_W = 5;

    // Operand size codes on the transfer size lines.
    localparam logic [1:0] SIZE_LONG = 2'h0;
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_LINE = 2'h3;

    // Bank port size codes.
    localparam logic [1:0] PORT_32 = 2'h0;
    localparam logic [1:0] PORT_8 = 2'h1;
    localparam logic [1:0] PORT_16 = 2'h2;

    // Bank page mode codes.
    localparam logic [1:0] PAGE_NORMAL = 2'h0;
    localparam logic [1:0] PAGE_BURST = 2'h1;
    localparam logic [1:0] PAGE_FAST = 2'h2;

    // Timing word fields: extra row-to-column clocks, extra precharge clocks.
    localparam int TIM_RCD_LSB = 0;
    localparam int TIM_RP_LSB = 2;
    localparam int TIM_FIELD_W = 2;

    // Reset values.
    localparam logic [ADDR_W-1:0] ADDR_RST = 28'h0000000;
    localparam logic [LANE_W-1:0] LANES_NONE = 4'h0;

    // Column address map: low column bits are moved up onto the row pins.
    localparam int ROW_LSB = 9;

    // Sequencer states, one-hot.
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_DECODE = 8'h02,
        ST_WAIT = 8'h04,
        ST_ROW = 8'h08,
        ST_COL = 8'h10,
        ST_ACK = 8'h20,
        ST_PRE = 8'h40,
        ST_TAIL = 8'h80
    } emd_state_type;

endpackage

// >>> core/emd_decode_if.sv
`timescale 1ns/1ps
`default_nettype none

interface emd_decode_if;
    import emd_pkg::*;

    // Captured request and bank setup.
    logic [ADDR_W-1:0] addr;
    logic [1:0] size;
    logic [1:0] port_size;
    logic [1:0] page_mode;
    logic [ADDR_W-1:0] bank_base;
    logic [ADDR_W-1:0] bank_mask;
    logic bank_en;
    // Decode results.
    logic hit;
    logic burst_page;
    logic [SUB_W-1:0] sub_count;
    logic [LANE_W-1:0] lanes;
    logic [2:0] step;

    modport seq (output addr, size, port_size, page_mode, bank_base, bank_mask, bank_en,
                 input hit, burst_page, sub_count, lanes, step);
    modport dec (input addr, size, port_size, page_mode, bank_base, bank_mask, bank_en,
                 output hit, burst_page, sub_count, lanes, step);
endinterface

`default_nettype wire

// >>> core/emd_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module emd_decoder
    import emd_pkg::*;
#(
    parameter int BANK_LSB = 17
)(
    // Decode request and result.
    emd_decode_if.dec dif
);

    if (BANK_LSB < ROW_LSB || BANK_LSB >= ADDR_W)
    begin : g_chk
        $error("BANK_LSB out of range");
    end

    logic [ADDR_W-1:0] diff;
    logic [4:0] op_bytes;
    logic [1:0] port_log;

    // Hit test ignores masked bits; bits below the bank granule never matter.
    assign diff = (dif.addr ^ dif.bank_base) & ~dif.bank_mask;
    assign dif.hit = dif.bank_en && (diff[ADDR_W-1:BANK_LSB] == '0);

    // Fast page banks are served as burst page for this master.
    assign dif.burst_page = (dif.page_mode != PAGE_NORMAL);

    // Operand width in bytes, port width as log2 of its bytes.
    always_comb
    begin
        op_bytes = 5'h04;
        if (dif.size == SIZE_BYTE)
        begin
            op_bytes = 5'h01;
        end
        else if (dif.size == SIZE_WORD)
        begin
            op_bytes = 5'h02;
        end
        else if (dif.size == SIZE_LINE)
        begin
            op_bytes = 5'h10;
        end
        port_log = 2'h2;
        if (dif.port_size == PORT_8)
        begin
            port_log = 2'h0;
        end
        else if (dif.port_size == PORT_16)
        begin
            port_log = 2'h1;
        end
    end

    // A wider operand than the port becomes a burst of port-wide pieces.
    assign dif.sub_count = ((op_bytes >> port_log) == 5'h00) ? 5'h01 :
        (op_bytes >> port_log);
    assign dif.step = 3'(3'h1 << port_log);

    // Lane 0 is the most significant byte lane.
    always_comb
    begin
        dif.lanes = 4'hf;
        if (port_log == 2'h0)
        begin
            dif.lanes = 4'h1;
        end
        else if (port_log == 2'h1)
        begin
            dif.lanes = (op_bytes == 5'h01) ? 4'(4'h1 << dif.addr[0]) : 4'h3;
        end
        else if (op_bytes == 5'h01)
        begin
            dif.lanes = 4'(4'h1 << dif.addr[1:0]);
        end
        else if (op_bytes == 5'h02)
        begin
            dif.lanes = dif.addr[1] ? 4'hc : 4'h3;
        end
    end

endmodule

`default_nettype wire

// >>> core/emd_seq.sv
// Functional notes
// - Capture address and attributes when start sampled
// - Drive captured row address and write strobe
// - Row strobe asserts on following falling edge
// - Rising edge after extra row-to-column clocks: column address, acknowledge driven high
// - Column strobes of active lanes on falling edge
// - Acknowledge asserts one rising edge after column strobe
// - Final end negates strobes, acknowledge, frees address
// - Acknowledge released one clock after negation
// - Wide operand becomes burst from one start
// - Normal burst pieces wait for row precharge
// - Normal burst: five then four clocks fastest
// - Normal burst redrives row, increments column
// - Reads and writes share identical strobe timing
// - Burst page keeps row open, closes after
// - Burst page nonburst behaves as normal mode
// - Fast page bank runs as burst page
// - Mux disabled keeps address bus undriven
// - Refresh waits until this transfer completes
`timescale 1ns/1ps
`default_nettype none

module emd_seq
    import emd_pkg::*;
#(
    parameter int BANK_LSB = 17,
    parameter int RP_CNT_W = 3
)(
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_RESET,
    // External master bus.
    input wire logic i_TRANSFER_START_N,
    input wire logic i_READ,
    input wire logic [1:0] i_TRANSFER_SIZE,
    input wire logic [ADDR_W-1:0] i_A,
    output logic [ADDR_W-1:0] o_A,
    output logic o_A_OE,
    output logic o_TRANSFER_ACK_N,
    output logic o_TRANSFER_ACK_OE,
    // DRAM strobes.
    output logic o_RAS_N,
    output logic [LANE_W-1:0] o_CAS_N,
    output logic o_DRAM_WRITE_N,
    // Bank setup and timing.
    input wire logic i_BANK_EN,
    input wire logic [ADDR_W-1:0] i_BANK_BASE,
    input wire logic [ADDR_W-1:0] i_BANK_MASK,
    input wire logic [1:0] i_PORT_SIZE,
    input wire logic [1:0] i_PAGE_MODE,
    input wire logic [3:0] i_DRAM_TIMING_REG,
    input wire logic i_EXT_ADDR_MUX_ENABLE,
    // Refresh controller handshake.
    input wire logic i_REFRESH_ACTIVE,
    output logic o_REFRESH_HOLD
);

    if (RP_CNT_W < TIM_FIELD_W)
    begin : g_chk
        $error("RP_CNT_W too narrow for precharge field");
    end

    emd_decode_if dif ();

    emd_state_type state_q;
    logic [ADDR_W-1:0] addr_q;
    logic read_q;
    logic [1:0] size_q;
    logic [SUB_W-1:0] sub_left_q;
    logic [TIM_FIELD_W-1:0] wait_q;
    logic [RP_CNT_W-1:0] rp_cnt_q;
    logic ras_en_q;
    logic ras_tok_q;
    logic ras_seen_q;
    logic cas_en_q;
    logic cas_tok_q;
    logic cas_seen_q;
    logic [LANE_W-1:0] lanes_q;
    logic burst_page_q;
    logic [2:0] step_q;
    logic [TIM_FIELD_W-1:0] rcd_extra;
    logic [TIM_FIELD_W-1:0] rp_extra;
    logic prech_met;
    logic start_ok;
    logic ts_seen;
    logic last_sub;

    // Decoder sees the captured address and size, never the live request pins.
    assign dif.addr = addr_q;
    assign dif.size = size_q;
    assign dif.port_size = i_PORT_SIZE;
    assign dif.page_mode = i_PAGE_MODE;
    assign dif.bank_base = i_BANK_BASE;
    assign dif.bank_mask = i_BANK_MASK;
    assign dif.bank_en = i_BANK_EN;

    emd_decoder #(
        .BANK_LSB(BANK_LSB)
    ) u_dec (
        .dif(dif)
    );

    // Timing fields and start conditions.
    assign rcd_extra = i_DRAM_TIMING_REG[TIM_RCD_LSB +: TIM_FIELD_W];
    assign rp_extra = i_DRAM_TIMING_REG[TIM_RP_LSB +: TIM_FIELD_W];
    assign prech_met = (rp_cnt_q >= RP_CNT_W'(rp_extra));
    assign start_ok = prech_met && !i_REFRESH_ACTIVE;
    assign ts_seen = !i_TRANSFER_START_N;
    assign last_sub = (sub_left_q == 5'h01);

    // Column address: low address bits move onto the row pins.
    function automatic logic [ADDR_W-1:0] col_addr(input logic [ADDR_W-1:0] a);
        col_addr = {a[ADDR_W-ROW_LSB-1:0], a[ROW_LSB-1:0]};
    endfunction

    // Main sequencer. Reads and writes walk the same states; only the
    // write strobe level differs, the data bus is never touched here.
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            state_q <= ST_IDLE;
            addr_q <= ADDR_RST;
            read_q <= 1'b1;
            size_q <= SIZE_LONG;
            sub_left_q <= '0;
            wait_q <= '0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    if (ts_seen)
                    begin
                        addr_q <= i_A;
                        read_q <= i_READ;
                        size_q <= i_TRANSFER_SIZE;
                        state_q <= ST_DECODE;
                    end
                end
                ST_DECODE:
                begin
                    sub_left_q <= dif.sub_count;
                    wait_q <= rcd_extra;
                    if (!dif.hit)
                    begin
                        state_q <= ST_IDLE;
                    end
                    else if (start_ok)
                    begin
                        state_q <= ST_ROW;
                    end
                    else
                    begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT:
                begin
                    if (start_ok)
                    begin
                        state_q <= ST_ROW;
                    end
                end
                ST_ROW:
                begin
                    if (wait_q == '0)
                    begin
                        state_q <= ST_COL;
                    end
                    else
                    begin
                        wait_q <= wait_q - 2'h1;
                    end
                end
                ST_COL:
                begin
                    state_q <= ST_ACK;
                end
                ST_ACK:
                begin
                    sub_left_q <= sub_left_q - 5'h01;
                    wait_q <= rcd_extra;
                    if (!last_sub)
                    begin
                        addr_q <= addr_q + ADDR_W'(step_q);
                    end
                    if (last_sub)
                    begin
                        state_q <= ST_TAIL;
                    end
                    else if (burst_page_q)
                    begin
                        state_q <= ST_COL;
                    end
                    else
                    begin
                        state_q <= ST_PRE;
                    end
                end
                ST_PRE:
                begin
                    if (prech_met)
                    begin
                        state_q <= ST_ROW;
                    end
                end
                ST_TAIL:
                begin
                    // A start may arrive right after the address release.
                    if (ts_seen)
                    begin
                        addr_q <= i_A;
                        read_q <= i_READ;
                        size_q <= i_TRANSFER_SIZE;
                        state_q <= ST_DECODE;
                    end
                    else
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Bank attributes are frozen for the whole transfer.
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            lanes_q <= LANES_NONE;
            burst_page_q <= 1'b0;
            step_q <= 3'h1;
        end
        else if (state_q == ST_DECODE)
        begin
            lanes_q <= dif.lanes;
            burst_page_q <= dif.burst_page && (dif.sub_count != 5'h01);
            step_q <= dif.step;
        end
    end

    // Address pins: row first, column one clock plus the extra row-to-column clocks later, released at the end.
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            o_A <= ADDR_RST;
            o_A_OE <= 1'b0;
        end
        else if ((state_q == ST_DECODE && dif.hit && start_ok) ||
                 (state_q == ST_WAIT && start_ok))
        begin
            o_A <= addr_q;
            o_A_OE <= i_EXT_ADDR_MUX_ENABLE;
        end
        else if (state_q == ST_ROW && wait_q == '0)
        begin
            o_A <= col_addr(addr_q);
        end
        else if (state_q == ST_ACK)
        begin
            if (last_sub)
            begin
                o_A_OE <= 1'b0;
            end
            else if (burst_page_q)
            begin
                o_A <= col_addr(addr_q + ADDR_W'(step_q));
            end
            else
            begin
                o_A <= addr_q + ADDR_W'(step_q);
            end
        end
    end

    // Write strobe follows direction; identical timing for both.
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            o_DRAM_WRITE_N <= 1'b1;
        end
        else if (state_q == ST_DECODE && dif.hit)
        begin
            o_DRAM_WRITE_N <= read_q;
        end
        else if (state_q == ST_TAIL || state_q == ST_IDLE)
        begin
            o_DRAM_WRITE_N <= 1'b1;
        end
    end

    // Acknowledge: driven high at column time, low for one clock, then
    // driven high one clock more before release.
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            o_TRANSFER_ACK_N <= 1'b1;
            o_TRANSFER_ACK_OE <= 1'b0;
        end
        else if (state_q == ST_ROW && wait_q == '0)
        begin
            o_TRANSFER_ACK_N <= 1'b1;
            o_TRANSFER_ACK_OE <= 1'b1;
        end
        else if (state_q == ST_COL)
        begin
            o_TRANSFER_ACK_N <= 1'b0;
        end
        else if (state_q == ST_ACK)
        begin
            o_TRANSFER_ACK_N <= 1'b1;
        end
        else if (state_q == ST_TAIL)
        begin
            o_TRANSFER_ACK_OE <= 1'b0;
        end
    end

    // Row strobe request. Each new assertion flips a token so the
    // falling-edge half can tell a fresh request from a stale one.
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            ras_en_q <= 1'b0;
            ras_tok_q <= 1'b0;
        end
        else if (state_q == ST_DECODE ? (dif.hit && start_ok) :
                 (state_q == ST_WAIT && start_ok) || (state_q == ST_PRE && prech_met))
        begin
            ras_en_q <= 1'b1;
            ras_tok_q <= !ras_tok_q;
        end
        else if (state_q == ST_ACK && (last_sub || !burst_page_q))
        begin
            ras_en_q <= 1'b0;
        end
    end

    // Column strobe request, with its own token for page-mode gaps.
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            cas_en_q <= 1'b0;
            cas_tok_q <= 1'b0;
        end
        else if (state_q == ST_ROW && wait_q == '0)
        begin
            cas_en_q <= 1'b1;
            cas_tok_q <= !cas_tok_q;
        end
        else if (state_q == ST_ACK)
        begin
            cas_en_q <= !last_sub && burst_page_q;
            cas_tok_q <= !cas_tok_q;
        end
    end

    // Falling-edge halves: strobes assert half a clock after the request.
    always_ff @(negedge I_CLK)
    begin
        if (I_RESET)
        begin
            ras_seen_q <= 1'b0;
            cas_seen_q <= 1'b0;
        end
        else
        begin
            ras_seen_q <= ras_tok_q;
            cas_seen_q <= cas_tok_q;
        end
    end

    // Strobes assert on a falling edge and negate on a rising edge, so each
    // is the match of two flops of opposite edges rather than a single flop.
    assign o_RAS_N = !(ras_en_q && (ras_seen_q == ras_tok_q));
    assign o_CAS_N = (cas_en_q && (cas_seen_q == cas_tok_q)) ? ~lanes_q : 4'hf;

    // Precharge counter restarts at every row negation and during refresh.
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            rp_cnt_q <= '1;
        end
        else if ((ras_en_q && state_q == ST_ACK && (last_sub || !burst_page_q)) ||
                 i_REFRESH_ACTIVE)
        begin
            rp_cnt_q <= '0;
        end
        else if (rp_cnt_q != '1)
        begin
            rp_cnt_q <= rp_cnt_q + 1'b1;
        end
    end

    // Refresh is held off from the decode of a hit, one clock after capture, until the final piece ends.
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            o_REFRESH_HOLD <= 1'b0;
        end
        else if (state_q == ST_DECODE)
        begin
            o_REFRESH_HOLD <= dif.hit;
        end
        else if (state_q == ST_ACK && last_sub)
        begin
            o_REFRESH_HOLD <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// >>> tb/emd_seq_chk.sv
`timescale 1ns/1ps
`default_nettype none

module emd_seq_chk
    import emd_pkg::*;
(
    // Clock and reset.
    input wire logic I_CLK,
    input wire logic I_RESET,
    // Watched pins.
    input wire logic i_EXT_ADDR_MUX_ENABLE,
    input wire logic o_A_OE,
    input wire logic o_TRANSFER_ACK_N,
    input wire logic o_TRANSFER_ACK_OE,
    input wire logic o_RAS_N,
    input wire logic [LANE_W-1:0] o_CAS_N,
    input wire logic o_REFRESH_HOLD
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);

    // Column phase: acknowledge driven negated first, then one low clock.
    sequence s_col;
        $rose(o_TRANSFER_ACK_OE) ##0 o_TRANSFER_ACK_N;
    endsequence
    sequence s_pulse;
        !o_TRANSFER_ACK_N ##1 o_TRANSFER_ACK_N;
    endsequence

    a_col_then_ack: assert property (s_col |=> s_pulse)
        else $error("acknowledge did not follow the column phase");
    a_ack_pulse: assert property ($fell(o_TRANSFER_ACK_N) |=>
        o_TRANSFER_ACK_N && o_TRANSFER_ACK_OE)
        else $error("acknowledge low for more than one clock");
    a_ack_after_cas: assert property ($fell(o_TRANSFER_ACK_N) |-> !o_RAS_N &&
        o_CAS_N != 4'hf && $past(o_CAS_N) != 4'hf)
        else $error("acknowledge without column strobe a clock earlier");
    a_row_first: assert property ($rose(o_A_OE) |-> !o_RAS_N && o_REFRESH_HOLD)
        else $error("row strobe missing after row address drive");
    a_end_release: assert property ($fell(o_REFRESH_HOLD) |-> !o_A_OE && o_RAS_N &&
        o_CAS_N == 4'hf && o_TRANSFER_ACK_N)
        else $error("strobes or address still active after final piece");
    a_ack_release: assert property ($fell(o_REFRESH_HOLD) |->
        o_TRANSFER_ACK_OE ##1 !o_TRANSFER_ACK_OE)
        else $error("acknowledge not released one clock after the end");
    a_mux_off: assert property (!i_EXT_ADDR_MUX_ENABLE |-> !o_A_OE)
        else $error("address driven with multiplexing disabled");
    a_hold_during: assert property (o_TRANSFER_ACK_OE && !o_TRANSFER_ACK_N |->
        o_REFRESH_HOLD)
        else $error("refresh not held off during a transfer");
endmodule

bind emd_seq emd_seq_chk u_chk (
    .I_CLK(I_CLK),
    .I_RESET(I_RESET),
    .i_EXT_ADDR_MUX_ENABLE(i_EXT_ADDR_MUX_ENABLE),
    .o_A_OE(o_A_OE),
    .o_TRANSFER_ACK_N(o_TRANSFER_ACK_N),
    .o_TRANSFER_ACK_OE(o_TRANSFER_ACK_OE),
    .o_RAS_N(o_RAS_N),
    .o_CAS_N(o_CAS_N),
    .o_REFRESH_HOLD(o_REFRESH_HOLD)
);

`default_nettype wire

// >>> tb/emd_master_model.sv
`timescale 1ns/1ps
`default_nettype none

module emd_master_model
    import emd_pkg::*;
(
    // Clock and acknowledge from the device.
    input wire logic i_clk,
    input wire logic i_ack_n,
    input wire logic i_ack_oe,
    // Request lines towards the device.
    output logic o_start_n,
    output logic o_read,
    output logic [1:0] o_size,
    output logic [ADDR_W-1:0] o_addr
);
    logic go;
    logic read_q;
    logic [1:0] size_q;
    logic [ADDR_W-1:0] addr_q;

    // Idle values at time zero, before the first falling edge.
    initial
    begin
        go = 1'b0;
        o_start_n = 1'b1;
        o_read = 1'b1;
        o_size = 2'h0;
        o_addr = 28'h0000000;
    end

    // Lines change on the falling edge; a released bus shows a moving pattern,
    // so a sequencer that samples it late cannot pick up the old address.
    always @(negedge i_clk)
    begin
        o_start_n <= !go;
        o_addr <= go ? addr_q : ~o_addr;
        o_read <= go ? read_q : ~o_read;
        o_size <= go ? size_q : ~o_size;
    end

    // One start per operand, then wait for every piece before the next start.
    task automatic start(input logic [ADDR_W-1:0] a, input logic [1:0] sz, input logic rd,
                         input int n);
        int k;
        addr_q = a;
        size_q = sz;
        read_q = rd;
        go = 1'b1;
        @(posedge i_clk);
        go = 1'b0;
        k = 0;
        while (k < n)
        begin
            @(posedge i_clk);
            if (i_ack_oe === 1'b1 && i_ack_n === 1'b0)
                k++;
        end
    endtask
endmodule

`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import emd_pkg::*;
    logic clk, rst, start_n, rd, mux, refr, bank_en, a_oe, ack_n, ack_oe, ras_n, wr_n, hold;
    logic e_rd, chk0, a_oe_q;
    logic [1:0] size, port, page;
    logic [3:0] tim, cas_n, e_lanes;
    logic [27:0] a_in, a_out, base, mask, e_addr, ad;
    logic [31:0] seed;
    int n_mismatch, compares, cyc, t0, t1, got, ras_hi, e_n, e_first, e_gap, e_pb;

    emd_seq DUT (.I_CLK(clk), .I_RESET(rst), .i_TRANSFER_START_N(start_n), .i_READ(rd),
        .i_TRANSFER_SIZE(size), .i_A(a_in), .o_A(a_out), .o_A_OE(a_oe),
        .o_TRANSFER_ACK_N(ack_n), .o_TRANSFER_ACK_OE(ack_oe), .o_RAS_N(ras_n),
        .o_CAS_N(cas_n), .o_DRAM_WRITE_N(wr_n), .i_BANK_EN(bank_en), .i_BANK_BASE(base),
        .i_BANK_MASK(mask), .i_PORT_SIZE(port), .i_PAGE_MODE(page), .i_DRAM_TIMING_REG(tim),
        .i_EXT_ADDR_MUX_ENABLE(mux), .i_REFRESH_ACTIVE(refr), .o_REFRESH_HOLD(hold));
    emd_master_model master (.i_clk(clk), .i_ack_n(ack_n), .i_ack_oe(ack_oe),
        .o_start_n(start_n), .o_read(rd), .o_size(size), .o_addr(a_in));

    // Free-running system clock.
    always #25 clk = ~clk;

    // Shift register source of all random stimulus.
    function automatic logic [31:0] rnd();
        repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic complete_run();
        $display("n_mismatch %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic cmp_sig(input logic [27:0] g, input logic [27:0] e, input string what);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s is %h, expected %h", $time, what, g, e);
        end
    endtask

    task automatic cmp_num(input int g, input int e, input string what);
        compares++;
        if (g != e)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s is %0d, expected %0d", $time, what, g, e);
        end
    endtask

    // No address, acknowledge, row strobe or column strobe may be driven; the write strobe is not checked.
    task automatic idle_chk();
        cmp_sig(28'({a_oe, ack_oe, ras_n, cas_n}), 28'h000001f, "idle pins");
    endtask

    // Active lanes of one piece; lane 0 is the most significant byte lane.
    function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a,
                                         input logic burst);
        if (port == PORT_8)
            return 4'h1;
        if (port == PORT_16)
            return (sz == SIZE_BYTE && !burst) ? 4'h1 << a[0] : 4'h3;
        if (burst || sz == SIZE_LONG)
            return 4'hf;
        if (sz == SIZE_BYTE)
            return 4'h1 << a;
        return a[1] ? 4'hc : 4'h3;
    endfunction

    // Settings change on a falling edge with the bank idle long enough for precharge.
    task automatic cfg(input logic [1:0] pt, input logic [1:0] pg, input logic [3:0] t,
                       input logic m);
        @(negedge clk);
        port = pt;
        page = pg;
        tim = t;
        mux = m;
        repeat (5) @(posedge clk);
        #1;
    endtask

    // One operand from the master, with the expected shape of every piece.
    task automatic xfer(input logic [27:0] a, input logic [1:0] sz, input logic r,
                        input logic hit);
        int ob;
        ob = (sz == SIZE_BYTE) ? 1 : (sz == SIZE_WORD) ? 2 : (sz == SIZE_LINE) ? 16 : 4;
        e_pb = (port == PORT_8) ? 1 : (port == PORT_16) ? 2 : 4;
        e_addr = a & ~(28'(ob) - 28'h1);
        e_rd = r;
        e_n = !hit ? 0 : (ob > e_pb) ? ob / e_pb : 1;
        e_lanes = lanes(sz, e_addr[1:0], ob > e_pb);
        e_first = 4 + int'(tim[1:0]);
        e_gap = (page != PAGE_NORMAL) ? 2 : 4 + int'(tim[1:0]) + int'(tim[3:2]);
        master.start(e_addr, sz, r, e_n);
        #1;
        cmp_num(got, e_n, "pieces");
        cmp_num(ras_hi, page != PAGE_NORMAL ? 0 : (e_n - 1) * (1 + int'(tim[3:2])),
                "precharge");
    endtask

    // Reference model: follows every capture and checks each acknowledged piece.
    always @(posedge clk)
    begin
        cyc++;
        if (a_oe === 1'b1 && a_oe_q !== 1'b1)
            cmp_sig(a_out, e_addr, "row address");
        if (start_n === 1'b0)
        begin
            t0 = cyc;
            got = 0;
            ras_hi = 0;
        end
        else if (ack_oe === 1'b1 && ack_n === 1'b0)
        begin
            ad = e_addr + 28'(got * e_pb);
            if (got == 0)
            begin
                t1 = cyc;
                if (chk0)
                    cmp_num(cyc - t0, e_first, "first ack");
            end
            else
                cmp_num(cyc - t1, got * e_gap, "ack spacing");
            cmp_sig(28'({a_oe, cas_n, ras_n, wr_n, hold}),
                28'({mux, ~e_lanes, 1'b0, e_rd, 1'b1}), "strobes");
            if (mux)
                cmp_sig(a_out, {ad[18:0], ad[8:0]}, "column");
            got++;
        end
        else if (got > 0 && got < e_n && ras_n === 1'b1)
        begin
            ras_hi++;
            if (mux)
                cmp_sig(a_out, e_addr + 28'(got * e_pb), "row again");
        end
        a_oe_q = a_oe;
    end

    // Watchdog well beyond the longest expected run.
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("unexpected at %0t: watchdog expired", $time);
        complete_run();
    end

    // Main sequence.
    initial
    begin
        clk = 0;
        rst = 1;
        refr = 0;
        bank_en = 1;
        base = 28'h2000000;
        mask = 28'h01fffff;
        port = PORT_8;
        page = PAGE_NORMAL;
        tim = 4'h0;
        mux = 1;
        seed = 32'h00010d76;
        {n_mismatch, compares, cyc, t0, t1, got, ras_hi, e_n} = '0;
        chk0 = 1;
        e_addr = 28'h0000000;
        repeat (20) @(negedge clk);
        rst = 0;
        idle_chk();
        cfg(PORT_8, PAGE_NORMAL, 4'h0, 1);
        xfer(28'h2000101, SIZE_BYTE, 1, 1);
        xfer(28'h2000102, SIZE_BYTE, 0, 1);
        cfg(PORT_16, PAGE_NORMAL, 4'h0, 1);
        xfer(28'h2000204, SIZE_LONG, 0, 1);
        cfg(PORT_8, PAGE_BURST, 4'h0, 1);
        xfer(28'h2000306, SIZE_WORD, 1, 1);
        xfer(28'h4000000, SIZE_LONG, 1, 0);
        repeat (6) @(negedge clk) idle_chk();
        @(negedge clk);
        bank_en = 0;
        @(posedge clk);
        #1;
        xfer(28'h2000000, SIZE_LONG, 1, 0);
        repeat (6) @(negedge clk) idle_chk();
        bank_en = 1;
        refr = 1;
        chk0 = 0;
        cfg(PORT_32, PAGE_NORMAL, 4'h0, 1);
        fork
            xfer(28'h2000400, SIZE_LONG, 1, 1);
            begin
                repeat (6) @(negedge clk) idle_chk();
                refr = 0;
            end
        join
        chk0 = 1;
        for (int i = 0; i < 30; i++)
        begin
            ad = 28'(rnd());
            cfg(ad[1:0] == 2'h3 ? PORT_32 : ad[1:0], ad[3:2],
                ad[3:2] == PAGE_NORMAL ? ad[7:4] : 4'h0, ad[9:8] != 2'h0);
            ad = 28'(rnd());
            xfer(base | (ad & mask), ad[27:26], ad[25], 1);
        end
        complete_run();
    end
endmodule

`default_nettype wire
